// file: shared/dac_ladder_consts.vh
// Register addresses, field positions and frame constants for the DAC control block.
// Included by the control module file of this block; holds definitions only.
`ifndef DAC_LADDER_CONSTS_VH
`define DAC_LADDER_CONSTS_VH

// Register addresses (5-bit serial address field)
`define ADDR_CODE_CH0 5'h00
`define ADDR_CODE_CH1 5'h01
`define ADDR_POWER_DOWN 5'h08
`define ADDR_GAIN_VOLATILE 5'h0A
`define ADDR_LOCK_STATUS 5'h0B
`define ADDR_GAIN_NONVOLATILE 5'h1A

// Field positions
`define GAIN_CH0_BIT 8
`define GAIN_CH1_BIT 9
`define PD_CH0_LSB 0
`define PD_CH1_LSB 2

// Reset values
`define GAIN_RESET 2'h0
`define PD_RESET 4'h0

// Command codes in bits 2:1 of the command byte
`define CMD_WRITE 2'h0
`define CMD_READ 2'h3

// Frame layout: 8 command bits then 16 data bits
`define CMD_BITS 5'h08
`define FRAME_BITS 5'h18

`endif

// file: hdl/pin_sync.v
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to clk_in; output is a clean level on clk_in.
`timescale 1ns/1ps

module pin_sync #(
   parameter RESET_LEVEL = 1'b0
) (
   // Clock and reset
   input wire clk_in,
   input wire nrst_in,
   // Pin and filtered level
   input wire pin_in,
   output reg level_out
);

   reg stage1;
   reg stage2;
   reg stage3;

   // First stage feeds only the second; the level moves once stages two and three agree
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         stage1 <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         stage3 <= RESET_LEVEL;
         level_out <= RESET_LEVEL;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            level_out <= stage3;
         end
      end
   end

endmodule // pin_sync

// file: hdl/dac_gain_and_ladder_control.v
// Serial register bank and ladder control for a one- or two-channel resistor-ladder DAC.
// Assumes an SPI mode 0 host far slower than clk_in (at least 8 clocks per serial half period).
`timescale 1ns/1ps
`include "dac_ladder_consts.vh"

module dac_gain_and_ladder_control #(
   parameter RES_BITS = 12,
   parameter TWO_CH = 1,
   parameter [1:0] NV_GAIN_STORED = 2'h0
) (
   // Clock and reset
   input wire clk_in,
   input wire nrst_in,
   // Serial pins
   input wire sclk_in,
   input wire cs_n_in,
   input wire mosi_in,
   output reg miso_out,
   output reg miso_oe_out,
   // Lock setup from configuration memory, {ch1_b, ch1_a, ch0_b, ch0_a}
   input wire [3:0] lock_cfg_in,
   // Analog control
   output reg [RES_BITS-1:0] tap_ch0_out,
   output reg [RES_BITS-1:0] tap_ch1_out,
   output reg gain_sel_ch0_out,
   output reg gain_sel_ch1_out,
   output reg ref_connect_ch0_out,
   output reg ref_connect_ch1_out
);

   // Ladder size and field masks for this build
   localparam [12:0] LADDER_ELEMENTS = 13'h0001 << RES_BITS;
   localparam [RES_BITS-1:0] TAP_MAX = LADDER_ELEMENTS[RES_BITS-1:0] - 1'b1;
   localparam [1:0] GAIN_MASK = TWO_CH ? 2'h3 : 2'h1;
   localparam [3:0] PD_MASK = TWO_CH ? 4'hF : 4'h3;

   // Synchronised pins
   // Reset levels match the idle pins, so no false edge or select follows reset
   wire sclk_lvl;
   wire cs_n_lvl;
   wire mosi_lvl;

   pin_sync #(.RESET_LEVEL(1'b0)) sync_sclk (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .pin_in(sclk_in),
      .level_out(sclk_lvl)
   );
   pin_sync #(.RESET_LEVEL(1'b1)) sync_cs (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .pin_in(cs_n_in),
      .level_out(cs_n_lvl)
   );
   pin_sync #(.RESET_LEVEL(1'b0)) sync_mosi (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .pin_in(mosi_in),
      .level_out(mosi_lvl)
   );

   // Register state
   // Lock flags are not stored here; they are read live from the setup input
   reg [RES_BITS-1:0] code_ch0;
   reg [RES_BITS-1:0] code_ch1;
   reg [3:0] power_down;
   reg [1:0] gain_vol;
   reg [1:0] gain_nv;
   reg recall_pending;

   // Serial engine state
   reg sclk_prev;
   reg [4:0] bit_count;
   reg [23:0] rx_shift;
   reg [15:0] tx_shift;
   reg reading;

   wire rise = sclk_lvl & ~sclk_prev;
   wire fall = ~sclk_lvl & sclk_prev;
   wire [23:0] rx_next = {rx_shift[22:0], mosi_lvl};
   wire [4:0] cmd_addr = rx_next[7:3];
   wire [1:0] cmd_code = rx_next[2:1];
   wire [4:0] wr_addr = rx_next[23:19];
   wire [1:0] wr_code = rx_next[18:17];
   wire [15:0] wr_data = rx_next[15:0];
   // Frame still taking bits; rises past the last data bit are ignored
   wire frame_open = (bit_count != `FRAME_BITS);

   // Gain word; only the gain bits of present channels can ever read as one
   function [15:0] gain_word;
      input [1:0] gain;
      begin
         gain_word = 16'h0000;
         gain_word[`GAIN_CH0_BIT] = gain[0];
         gain_word[`GAIN_CH1_BIT] = gain[1] & GAIN_MASK[1];
      end
   endfunction

   // Code field of a write; bits above the resolution are dropped, never clamped
   function [RES_BITS-1:0] code_field;
      input [15:0] data;
      begin
         code_field = data[RES_BITS-1:0] & TAP_MAX;
      end
   endfunction

   // Ladder stays tied to the reference only while both power-down bits are clear
   function ladder_live;
      input [1:0] pd_pair;
      begin
         ladder_live = (pd_pair == 2'h0);
      end
   endfunction

   // Readback mux; unused positions fold to zero
   function [15:0] read_word;
      input [4:0] addr;
      begin
         case (addr)
            `ADDR_CODE_CH0: read_word = {{(16-RES_BITS){1'b0}}, code_ch0};
            `ADDR_CODE_CH1: read_word = TWO_CH ? {{(16-RES_BITS){1'b0}}, code_ch1} : 16'h0000;
            `ADDR_POWER_DOWN: read_word = {12'h000, power_down & PD_MASK};
            `ADDR_GAIN_VOLATILE: read_word = gain_word(gain_vol);
            `ADDR_LOCK_STATUS: read_word = {12'h000, lock_cfg_in & PD_MASK};
            `ADDR_GAIN_NONVOLATILE: read_word = gain_word(gain_nv);
            default: read_word = 16'h0000;
         endcase
      end
   endfunction

   // Serial frame: command byte, then 16 data bits in or out
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         sclk_prev <= 1'b0;
         bit_count <= 5'h00;
         rx_shift <= 24'h000000;
         tx_shift <= 16'h0000;
         reading <= 1'b0;
         miso_out <= 1'b0;
         miso_oe_out <= 1'b0;
      end else begin
         sclk_prev <= sclk_lvl;
         if (cs_n_lvl) begin
            // Deselect aborts any partial frame; nothing is committed
            bit_count <= 5'h00;
            reading <= 1'b0;
            miso_oe_out <= 1'b0;
            miso_out <= 1'b0;
         end else begin
            if (rise && frame_open) begin
               rx_shift <= rx_next;
               bit_count <= bit_count + 5'h01;
               // Read word is fetched at the eighth rise, before the first data fall
               if (bit_count == `CMD_BITS - 5'h01 && cmd_code == `CMD_READ) begin
                  reading <= 1'b1;
                  tx_shift <= read_word(cmd_addr);
               end
            end
            // Mode 0: data changes on the falling edge, host samples on the rising
            if (fall && reading && frame_open) begin
               miso_out <= tx_shift[15];
               miso_oe_out <= 1'b1;
               tx_shift <= {tx_shift[14:0], 1'b0};
            end
         end
      end
   end

   // Only a full write frame commits; reads and unknown codes never do
   wire commit = !cs_n_lvl && rise && bit_count == `FRAME_BITS - 5'h01 && wr_code == `CMD_WRITE;

   // Register writes, gain recall after reset
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         code_ch0 <= {RES_BITS{1'b0}};
         code_ch1 <= {RES_BITS{1'b0}};
         power_down <= `PD_RESET;
         gain_vol <= `GAIN_RESET;
         gain_nv <= NV_GAIN_STORED;
         recall_pending <= 1'b1;
      end else begin
         // Recall runs once, on the first clock after reset
         recall_pending <= 1'b0;
         if (recall_pending) begin
            gain_vol <= gain_nv & GAIN_MASK;
         end
         if (commit) begin
            case (wr_addr)
               // Upper data bits are dropped, so the code tops out at TAP_MAX
               `ADDR_CODE_CH0: code_ch0 <= code_field(wr_data);
               `ADDR_CODE_CH1: if (TWO_CH) code_ch1 <= code_field(wr_data);
               `ADDR_POWER_DOWN: power_down <= wr_data[3:0] & PD_MASK;
               `ADDR_GAIN_VOLATILE: gain_vol <= wr_data[9:8] & GAIN_MASK;
               `ADDR_GAIN_NONVOLATILE: gain_nv <= wr_data[9:8] & GAIN_MASK;
               default: ; // Lock status and unmapped addresses ignore writes
            endcase
         end
      end
   end

   // Analog controls, registered so they stay glitch-free
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         tap_ch0_out <= {RES_BITS{1'b0}};
         tap_ch1_out <= {RES_BITS{1'b0}};
         gain_sel_ch0_out <= 1'b0;
         gain_sel_ch1_out <= 1'b0;
         ref_connect_ch0_out <= 1'b0;
         ref_connect_ch1_out <= 1'b0;
      end else begin
         // Single-channel builds hold every channel one control at zero
         tap_ch0_out <= code_ch0;
         tap_ch1_out <= TWO_CH ? code_ch1 : {RES_BITS{1'b0}};
         gain_sel_ch0_out <= gain_vol[`GAIN_CH0_BIT-8];
         gain_sel_ch1_out <= TWO_CH ? gain_vol[`GAIN_CH1_BIT-8] : 1'b0;
         ref_connect_ch0_out <= ladder_live(power_down[`PD_CH0_LSB+1:`PD_CH0_LSB]);
         ref_connect_ch1_out <= TWO_CH ? ladder_live(power_down[`PD_CH1_LSB+1:`PD_CH1_LSB]) : 1'b0;
      end
   end

endmodule // dac_gain_and_ladder_control

// file: bench/spi_host_model.sv
// SPI mode 0 host driving the serial pins of the DAC block.
// Assumes clk_in is the block clock; pins change at its falling edge.
`timescale 1ns/1ps
module spi_host_model (
   input wire clk_in,
   input wire miso_in,
   output reg sclk_out = 1'b0,
   output reg cs_n_out = 1'b1,
   output reg mosi_out = 1'b0
);
   // One frame of n bits; slow half period suits the pin synchroniser
   task xfer(input [23:0] w, input integer n, output [15:0] q);
      integer i;
      begin
         q = 16'h0000;
         @(negedge clk_in) cs_n_out = 1'b0;
         for (i = 0; i < n; i = i + 1) begin
            mosi_out = w[23-i];
            repeat (10) @(negedge clk_in);
            q = {q[14:0], miso_in}; // Settled well before the rise
            sclk_out = 1'b1;
            repeat (10) @(negedge clk_in);
            sclk_out = 1'b0;
         end
         repeat (10) @(negedge clk_in);
         cs_n_out = 1'b1;
         mosi_out = ~mosi_out; // No stale bit once released
         repeat (10) @(negedge clk_in); // Select must stay high past the pin filter
      end
   endtask
endmodule // spi_host_model

// file: bench/dac_gain_and_ladder_control_assertions.sv
// Port checker for the DAC control block.
// Assumes one clock domain; bound to every instance.
`timescale 1ns/1ps
module dac_gain_and_ladder_control_assertions #(
   parameter RES_BITS = 12,
   parameter TWO_CH = 1,
   parameter [1:0] NV_GAIN_STORED = 2'h0
) (
   input wire clk_in, nrst_in, sclk_in, cs_n_in, mosi_in, miso_out, miso_oe_out,
   input wire [3:0] lock_cfg_in,
   input wire [RES_BITS-1:0] tap_ch0_out, tap_ch1_out,
   input wire gain_sel_ch0_out, gain_sel_ch1_out, ref_connect_ch0_out, ref_connect_ch1_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // Reset clears all analog controls
   chk_reset_tap: assert property (disable iff (1'b0) !nrst_in |=> tap_ch0_out == 0 && tap_ch1_out == 0)
      else $error("tap not cleared");
   chk_reset_gain: assert property (disable iff (1'b0) !nrst_in |=> !gain_sel_ch0_out && !gain_sel_ch1_out)
      else $error("gain not cleared");
   chk_reset_ref: assert property (disable iff (1'b0) !nrst_in |=> !ref_connect_ch0_out && !ref_connect_ch1_out)
      else $error("ref not cleared");
   // Stored gain recalled shortly after release
   chk_gain_recall: assert property ($rose(nrst_in) ##3 1 |-> {gain_sel_ch1_out, gain_sel_ch0_out} == NV_GAIN_STORED)
      else $error("gain not recalled");
   // Data line released when deselected
   chk_oe_idle: assert property (cs_n_in [*6] |-> !miso_oe_out)
      else $error("miso driven while idle");
   // No change without a frame, once reset effects have settled
   chk_tap_hold: assert property (cs_n_in [*8] ##0 $past(nrst_in, 6) |-> $stable(tap_ch0_out) && $stable(tap_ch1_out))
      else $error("tap moved while idle");
   chk_gain_hold: assert property (cs_n_in [*8] ##0 $past(nrst_in, 6) |-> $stable(gain_sel_ch0_out) && $stable(gain_sel_ch1_out))
      else $error("gain moved while idle");
   chk_ref_hold: assert property (cs_n_in [*8] ##0 $past(nrst_in, 6) |-> $stable(ref_connect_ch0_out) && $stable(ref_connect_ch1_out))
      else $error("ref moved while idle");
endmodule // dac_gain_and_ladder_control_assertions
bind dac_gain_and_ladder_control dac_gain_and_ladder_control_assertions #(.RES_BITS(RES_BITS), .TWO_CH(TWO_CH),
   .NV_GAIN_STORED(NV_GAIN_STORED)) dac_gain_and_ladder_control_assertions_inst (.*);

// file: bench/dac_gain_and_ladder_control_bench.sv
// Self-checking bench for the DAC control block with an SPI host model.
// Assumes a 12-bit two-channel build whose stored gain doubles channel one.
`timescale 1ns/1ps
module dac_gain_and_ladder_control_bench;
   reg clk_in = 1'b0;
   reg nrst_in = 1'b0;
   reg [3:0] lock_cfg_in = 4'h5;
   wire sclk, cs_n, mosi, miso, oe, g0, g1, r0, r1;
   wire [11:0] t0, t1;
   integer n_errors = 0, tests_run = 0, i;
   reg [15:0] q;
   reg [36:0] rows [0:4];
   // Clock, 100 ns period
   initial forever #50 clk_in = ~clk_in;
   spi_host_model spi_host_model_inst (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
      .mosi_out(mosi));
   dac_gain_and_ladder_control #(.RES_BITS(12), .TWO_CH(1), .NV_GAIN_STORED(2'h2)) dac_gain_and_ladder_control_inst (
      .clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
      .miso_oe_out(oe), .lock_cfg_in(lock_cfg_in), .tap_ch0_out(t0), .tap_ch1_out(t1), .gain_sel_ch0_out(g0),
      .gain_sel_ch1_out(g1), .ref_connect_ch0_out(r0), .ref_connect_ch1_out(r1));
   task chk(input [15:0] g, input [15:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   // Commit lands a few clocks after the last rise, so settle first
   task wr(input [4:0] a, input [15:0] d, input integer n);
      begin
         spi_host_model_inst.xfer({a, 3'h0, d}, n, q);
         repeat (12) @(negedge clk_in);
      end
   endtask
   task give_verdict;
      begin
         $display("errors %0d checks %0d", n_errors, tests_run);
         if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_in);
      n_errors = n_errors + 1;
      give_verdict;
   end
   initial begin
      rows[0] = {5'h1A, 16'hFFFF, 16'h0300};
      rows[1] = {5'h1A, 16'h0100, 16'h0100};
      rows[2] = {5'h0B, 16'hFFFF, 16'h0005};
      rows[3] = {5'h0A, 16'h0100, 16'h0100};
      rows[4] = {5'h15, 16'hFFFF, 16'h0000};
      repeat (6) @(negedge clk_in);
      nrst_in = 1'b1;
      repeat (8) @(negedge clk_in);
      chk({14'h0, g1, g0}, 16'h0002);
      chk({4'h0, t0}, 16'h0000);
      chk({14'h0, r1, r0}, 16'h0003);
      // Write each row, read it back
      for (i = 0; i < 5; i = i + 1) begin
         wr(rows[i][36:32], rows[i][31:16], 24);
         spi_host_model_inst.xfer({rows[i][36:32], 3'h6, 16'h0}, 24, q);
         chk(q, rows[i][15:0]);
      end
      chk({14'h0, g1, g0}, 16'h0001);
      chk({15'h0, oe}, 16'h0000);
      wr(5'h00, 16'hFFFF, 24);
      chk({4'h0, t0}, 16'h0FFF);
      wr(5'h01, 16'h8005, 24);
      chk({4'h0, t1}, 16'h0005);
      wr(5'h08, 16'h0001, 24);
      chk({14'h0, r1, r0}, 16'h0002);
      wr(5'h0A, 16'h0300, 20); // Aborted frame changes nothing
      chk({14'h0, g1, g0}, 16'h0001);
      // Second reset in mid-run
      nrst_in = 1'b0;
      repeat (2) @(negedge clk_in);
      chk({4'h0, t0}, 16'h0000);
      nrst_in = 1'b1;
      repeat (8) @(negedge clk_in);
      chk({14'h0, g1, g0}, 16'h0002);
      chk({14'h0, r1, r0}, 16'h0003);
      give_verdict;
   end
endmodule // dac_gain_and_ladder_control_bench
